/* design/rst_pwr_pkg.sv */
// Purpose: Shared constants for the reset, power and fault sequencer
// Assumes: 40 MHz system clock
// Notes: Timing counts are derived from times in their own units
package rst_pwr_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int SUPPLY_TIMER_MS = 10;
  localparam int SUPPLY_TIMER_CYC = (CLK_HZ / 1000) * SUPPLY_TIMER_MS;
  localparam int RESET_OUT_HOLD_NS = 200;
  localparam int RESET_OUT_HOLD_CYC = (RESET_OUT_HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int BOOT_SEL_W = 3;
  localparam int ADDR_W = 32;
  localparam int TIMER_W = 24;
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 32'h00000000;
  localparam logic [BOOT_SEL_W-1:0] BOOT_SEL_RST = 3'h0;
  typedef enum logic [1:0]
  {
    ST_RESET = 2'h0,
    ST_RELEASE = 2'h1,
    ST_RUN = 2'h3,
    ST_SLEEP = 2'h2
  } seq_state_t;
endpackage

/* design/pin_sync.sv */
// Purpose: Three-stage synchroniser for one asynchronous pin
// Assumes: Input is asynchronous to clk
// Notes: Output changes only once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic pin, // Raw pin
  output logic level // Filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_next;

  // Accept a change only when the later two stages agree
  assign level_next = (s2_reg == s3_reg) ? s3_reg : level;

  // Synchroniser chain; stage one feeds stage two only
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      level <= RST_VAL;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level <= level_next;
    end
  end
endmodule

/* design/reset_power_fault_control.sv */
// Purpose: Reset, sleep-power and supply-fault sequencing
// Assumes: Pins arrive asynchronously; core events come from clk logic
// Notes: Fault response chooses sleep or exception by fault_to_exception
`timescale 1ns/10ps

// Functional notes
// - Drop supply_on_request whenever sleep is entered.
// - Battery fault enters sleep or raises an unmaskable imprecise exception.
// - While battery fault stays asserted, wakeups are ignored and sleep holds.
// - Supply fault enters sleep or raises an unmaskable imprecise exception.
// - Supply fault ignored after wakeup until the ten millisecond timer ends.
// - Hard reset is level sensitive, aborts current instruction, resets device.
// - On hard reset release execution starts at address zero.
// - Reset-out follows hard reset and releases before the first fetch; the code releases it on the same edge that fetch_enable rises.
// - Reset-out also asserts for sleep, watchdog and GPIO soft resets.
// - Test-access reset resets the boundary-scan and debug logic.
// - Board drives boot-select code; device boots according to it.
module reset_power_fault_control
  import rst_pwr_pkg::*;
#(
  parameter int SUPPLY_TIMER = rst_pwr_pkg::SUPPLY_TIMER_CYC
) (
  input wire logic clk, // 40 MHz clock
  input wire logic srst, // Synchronous reset
  input wire logic hard_reset_n, // Hard reset pin
  input wire logic battery_fault_n, // Main battery fault pin
  input wire logic supply_fault_n, // Supply fault pin
  input wire logic test_reset_n, // Test-access reset pin
  input wire logic [rst_pwr_pkg::BOOT_SEL_W-1:0] boot_select, // Boot device code pins
  input wire logic fault_to_exception, // 1: faults raise exception, 0: sleep
  input wire logic sleep_request, // Software sleep entry pulse
  input wire logic wakeup_event, // Wakeup source pulse
  input wire logic watchdog_reset, // Watchdog soft reset pulse
  input wire logic gpio_reset, // GPIO soft reset pulse
  output logic supply_on_request, // Power enable to supply
  output logic system_reset_out_n, // Reset-out pin
  output logic core_reset, // Whole-device reset to core
  output logic abort_instruction, // Abort current instruction pulse
  output logic fetch_enable, // Core may fetch
  output logic [rst_pwr_pkg::ADDR_W-1:0] start_address, // First fetch address
  output logic imprecise_abort, // Unmaskable imprecise data exception pulse
  output logic debug_reset, // Debug and scan logic reset
  output logic [rst_pwr_pkg::BOOT_SEL_W-1:0] boot_mode, // Latched boot selection
  output logic sleeping // Device is in sleep
);
  import rst_pwr_pkg::*;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic hard_n_s;
  logic batt_n_s;
  logic vdd_n_s;
  logic trst_n_s;
  logic [BOOT_SEL_W-1:0] boot_sel_s;
  logic batt_n_d_reg;
  logic vdd_n_d_reg;

  pin_sync #(.RST_VAL(1'b0)) u_sync_hard (.clk(clk), .srst(srst), .pin(hard_reset_n), .level(hard_n_s));
  pin_sync #(.RST_VAL(1'b1)) u_sync_batt (.clk(clk), .srst(srst), .pin(battery_fault_n), .level(batt_n_s));
  pin_sync #(.RST_VAL(1'b1)) u_sync_vdd (.clk(clk), .srst(srst), .pin(supply_fault_n), .level(vdd_n_s));
  pin_sync #(.RST_VAL(1'b0)) u_sync_trst (.clk(clk), .srst(srst), .pin(test_reset_n), .level(trst_n_s));

  // boot code rides the same three stages as hard reset, so both settle together
  generate
    for (genvar i = 0; i < BOOT_SEL_W; i++)
    begin : g_boot_sync
      pin_sync #(.RST_VAL(BOOT_SEL_RST[i])) u_sync_boot (
        .clk(clk), // System clock
        .srst(srst), // Synchronous reset
        .pin(boot_select[i]), // One boot code pin
        .level(boot_sel_s[i]) // Filtered bit
      );
    end
  endgenerate

  // ****************************************************
  // Event decode
  // ****************************************************
  seq_state_t state_reg;
  seq_state_t state_next;
  logic [TIMER_W-1:0] guard_reg;
  logic [TIMER_W-1:0] guard_next;
  logic [TIMER_W-1:0] hold_reg;
  logic [TIMER_W-1:0] hold_next;
  logic hard_active;
  logic batt_fall;
  logic vdd_fall;
  logic vdd_armed;
  logic fault_event;
  logic wake_ok;
  logic soft_reset;

  // Level sensitive hard reset; pin low means reset
  // level hard reset
  assign hard_active = ~hard_n_s;
  // Faults act on the assertion edge; a level would retrigger the exception
  assign batt_fall = batt_n_d_reg & ~batt_n_s;
  assign vdd_fall = vdd_n_d_reg & ~vdd_n_s;
  assign vdd_armed = (guard_reg == '0);
  assign fault_event = batt_fall | (vdd_fall & vdd_armed);
  assign wake_ok = wakeup_event & batt_n_s;
  assign soft_reset = watchdog_reset | gpio_reset;

  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RESET:
        if (!hard_active)
          state_next = ST_RELEASE;
      ST_RELEASE:
        if (hold_reg == '0)
          state_next = ST_RUN;
      ST_RUN:
        if (sleep_request || (fault_event && !fault_to_exception))
          state_next = ST_SLEEP;
        else if (soft_reset)
          state_next = ST_RELEASE;
      ST_SLEEP:
        if (wake_ok)
          state_next = ST_RELEASE;
    endcase
    if (hard_active)
      state_next = ST_RESET;
  end

  // Reset-out hold and supply guard counters
  // reset-out and fetch enable release together when the hold ends
  assign hold_next = (state_next == ST_RELEASE && state_reg != ST_RELEASE) ? TIMER_W'(RESET_OUT_HOLD_CYC) :
                     (hold_reg != '0) ? hold_reg - 1'b1 : hold_reg;
  // The guard restarts on every accepted wakeup, so a slow supply ramp is not seen as a fault
  assign guard_next = (state_reg == ST_SLEEP && wake_ok) ? TIMER_W'(SUPPLY_TIMER) :
                      (guard_reg != '0) ? guard_reg - 1'b1 : guard_reg;

  // ****************************************************
  // Output decode
  // ****************************************************
  logic power_next;
  logic rst_out_n_next;
  logic core_rst_next;
  logic run_next;
  logic sleep_next;
  logic abort_next;
  logic exc_next;
  logic boot_capture;

  // Level outputs follow the next state so they move on the same edge as the sequencer
  // power enable off in sleep
  assign power_next = (state_next != ST_SLEEP);
  assign rst_out_n_next = (state_next == ST_RUN);
  assign core_rst_next = (state_next == ST_RESET);
  assign run_next = (state_next == ST_RUN);
  assign sleep_next = (state_next == ST_SLEEP);
  assign abort_next = hard_active & (state_reg != ST_RESET);
  assign exc_next = (state_reg == ST_RUN) & fault_event & fault_to_exception & ~hard_active;
  assign boot_capture = (state_reg == ST_RESET);

  // ****************************************************
  // State and outputs
  // ****************************************************
  // Sequencer registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= ST_RESET;
      hold_reg <= '0;
      guard_reg <= '0;
      batt_n_d_reg <= 1'b1;
      vdd_n_d_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      hold_reg <= hold_next;
      guard_reg <= guard_next;
      batt_n_d_reg <= batt_n_s;
      vdd_n_d_reg <= vdd_n_s;
    end
  end

  // Sequencer-level outputs; a register per pin keeps them free of decode glitches
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      supply_on_request <= 1'b1;
      system_reset_out_n <= 1'b0;
      core_reset <= 1'b1;
      fetch_enable <= 1'b0;
      sleeping <= 1'b0;
    end
    else
    begin
      supply_on_request <= power_next;
      system_reset_out_n <= rst_out_n_next;
      core_reset <= core_rst_next;
      fetch_enable <= run_next;
      sleeping <= sleep_next;
    end
  end

  // Event pulses, debug reset and boot latch
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      abort_instruction <= 1'b0;
      start_address <= RESET_VECTOR;
      imprecise_abort <= 1'b0;
      debug_reset <= 1'b1;
      boot_mode <= BOOT_SEL_RST;
    end
    else
    begin
      abort_instruction <= abort_next;
      start_address <= RESET_VECTOR;
      imprecise_abort <= exc_next;
      debug_reset <= ~trst_n_s;
      // Boot pins are ignored after release, so a later strap change cannot move the boot
      if (boot_capture)
        boot_mode <= boot_sel_s;
    end
  end
endmodule

/* tb/board_model.sv */
// Purpose: Board supply, reset and boot strap model
// Assumes: Bench changes commands on falling edges
// Notes: Pins follow commands; no glitches are modelled
`timescale 1ns/10ps
module board_model (
  input wire logic stable, // Supply and oscillator settled
  input wire logic bad_batt, // Main battery low
  input wire logic bad_vdd, // Supply leaving regulation
  input wire logic [2:0] code, // Fitted boot device
  output logic hard_reset_n, // Hard reset pin
  output logic test_reset_n, // Test-access reset pin
  output logic [2:0] boot_select, // Boot code pins
  output logic battery_fault_n, // Battery fault pin
  output logic supply_fault_n // Supply fault pin
);
  assign hard_reset_n = stable;
  assign test_reset_n = hard_reset_n;
  assign boot_select = code;
  // Fault pins are active low
  assign battery_fault_n = !bad_batt;
  assign supply_fault_n = !bad_vdd;
endmodule

/* tb/reset_power_fault_control_checker.sv */
// Purpose: Port-level checks of the sequencer
// Assumes: Single clock domain, srst disables all
// Notes: Pin latency allowance covers the synchroniser
`timescale 1ns/10ps
module reset_power_fault_control_checker (
  input wire logic clk, // Clock
  input wire logic srst, // Sync reset
  input wire logic hard_reset_n, // Hard reset pin
  input wire logic battery_fault_n, // Battery fault pin
  input wire logic fault_to_exception, // Fault mode
  input wire logic wakeup_event, // Wakeup pulse
  input wire logic supply_on_request, // Power enable
  input wire logic system_reset_out_n, // Reset-out
  input wire logic core_reset, // Core reset
  input wire logic fetch_enable, // Fetch allowed
  input wire logic [rst_pwr_pkg::ADDR_W-1:0] start_address, // First fetch
  input wire logic imprecise_abort, // Exception pulse
  input wire logic [rst_pwr_pkg::BOOT_SEL_W-1:0] boot_mode, // Boot code
  input wire logic sleeping // In sleep
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_sleep_power_off: assert property (sleeping |-> !supply_on_request) else $error("power on in sleep");
  a_sleep_rst_out: assert property (sleeping |-> !system_reset_out_n) else $error("reset-out high in sleep");
  a_fetch_rst_out: assert property (fetch_enable |-> system_reset_out_n) else $error("fetch under reset");
  // Allowance for synchroniser plus output register
  a_hard_reset_out: assert property ((!hard_reset_n)[*8] |-> !system_reset_out_n && core_reset && !fetch_enable)
    else $error("hard reset not applied");
  a_start_at_zero: assert property (fetch_enable |-> start_address == '0) else $error("start not zero");
  a_batt_holds_sleep: assert property ((!battery_fault_n)[*6] ##0 (sleeping && wakeup_event) |=> sleeping)
    else $error("woke under battery fault");
  a_boot_mode_hold: assert property (fetch_enable && $past(fetch_enable) |-> $stable(boot_mode))
    else $error("boot mode moved");
  a_batt_to_sleep: assert property (fetch_enable && !fault_to_exception && $fell(battery_fault_n) |-> ##[1:8] sleeping)
    else $error("no sleep on battery fault");
  a_batt_to_abort: assert property (fetch_enable && fault_to_exception && $fell(battery_fault_n)
    |-> ##[1:8] imprecise_abort) else $error("no exception on battery fault");
  c_sleep: cover property ($rose(sleeping));
  c_abort: cover property (imprecise_abort);
  c_run: cover property ($rose(fetch_enable));
endmodule
bind reset_power_fault_control reset_power_fault_control_checker checker_i (.clk, .srst, .hard_reset_n,
  .battery_fault_n, .fault_to_exception, .wakeup_event, .supply_on_request, .system_reset_out_n, .core_reset,
  .fetch_enable, .start_address, .imprecise_abort, .boot_mode, .sleeping);

/* tb/reset_power_fault_control_tb.sv */
// Purpose: Self-checking bench for the sequencer
// Assumes: Inputs change on falling edges
// Notes: Guard timer shortened to keep the run brief
`timescale 1ns/10ps
module reset_power_fault_control_tb;
  import rst_pwr_pkg::*;
  logic clk = 0, srst = 1, stable = 0, bad_batt = 0, bad_vdd = 0, f2e = 0;
  logic [2:0] code = 3'h5;
  logic [3:0] ev = 4'h0;
  logic hard_reset_n, test_reset_n, battery_fault_n, supply_fault_n, supply_on_request, system_reset_out_n;
  logic core_reset, abort_instruction, fetch_enable, imprecise_abort, debug_reset, sleeping;
  logic [2:0] boot_select, boot_mode;
  logic [31:0] start_address;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  // Monitor bits: 0 reset-out, 1 fetch, 2 sleep, 3 exception, 4 abort
  wire [4:0] mon = {abort_instruction, imprecise_abort, sleeping, fetch_enable, !system_reset_out_n};
  always #12.5 clk = !clk;
  board_model board_model_i (.stable, .bad_batt, .bad_vdd, .code, .hard_reset_n, .test_reset_n, .boot_select,
    .battery_fault_n, .supply_fault_n);
  reset_power_fault_control #(.SUPPLY_TIMER(50)) reset_power_fault_control_i (.clk, .srst, .hard_reset_n,
    .battery_fault_n, .supply_fault_n, .test_reset_n, .boot_select, .fault_to_exception(f2e),
    .sleep_request(ev[0]), .wakeup_event(ev[1]), .watchdog_reset(ev[2]), .gpio_reset(ev[3]), .supply_on_request,
    .system_reset_out_n, .core_reset, .abort_instruction, .fetch_enable, .start_address, .imprecise_abort,
    .debug_reset, .boot_mode, .sleeping);
  task complete_run;
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Event pulse k: 0 sleep, 1 wake, 2 watchdog, 3 GPIO reset
  task pulse(input int k);
    @(negedge clk) ev = 4'h1 << k;
    @(negedge clk) ev = 4'h0;
  endtask
  // Bounded look for (or absence of) a monitor bit
  task await(input int w, input int n, input logic exp);
    logic hit;
    hit = 0;
    repeat (n)
    begin
      @(negedge clk);
      hit = hit | mon[w];
    end
    check(hit, exp);
  endtask
  task t_boot;
    check(debug_reset, 1);
    stable = 1;
    await(1, 30, 1);
    check(start_address, 0);
    check(boot_mode, 3'h5);
    check(debug_reset, 0);
    code = 3'h2;
    await(1, 5, 1);
    check(boot_mode, 3'h5);
  endtask
  task t_soft;
    for (int k = 0; k < 4; k++)
    begin
      if (k == 1)
        continue;
      pulse(k);
      await(0, 3, 1);
      if (k == 0)
      begin
        check(supply_on_request, 0);
        pulse(1);
      end
      await(1, 30, 1);
    end
  endtask
  task t_batt(input logic exc);
    f2e = exc;
    bad_batt = 1;
    await(exc ? 3 : 2, 10, 1);
    pulse(1);
    await(2, 3, !exc);
    bad_batt = 0;
    repeat (6) @(negedge clk);
    pulse(1);
    await(1, 30, 1);
  endtask
  task t_supply;
    f2e = 0;
    pulse(0);
    pulse(1);
    // Let the release hold end so the fault meets RUN while the guard still runs
    repeat (12) @(negedge clk);
    check(fetch_enable, 1);
    bad_vdd = 1;
    await(2, 20, 0);
    bad_vdd = 0;
    repeat (50) @(negedge clk);
    bad_vdd = 1;
    await(2, 10, 1);
    bad_vdd = 0;
    pulse(1);
    await(1, 30, 1);
  endtask
  task t_hard;
    stable = 0;
    await(4, 8, 1);
    check(mon[0], 1);
    check(core_reset, 1);
    check(debug_reset, 1);
    stable = 1;
    await(1, 30, 1);
    check(start_address, 0);
    check(boot_mode, 3'h2);
  endtask
  // ****************
  // Watchdog and main sequence
  // ****************
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      complete_run;
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    srst = 0;
    t_boot;
    t_soft;
    t_batt(0);
    t_batt(1);
    t_supply;
    t_hard;
    complete_run;
  end
endmodule
